/* File: src/cbcr_regs.sv */
// Configuration register bank of the differential clock fanout buffer
//
// Summary of operation
// RULE1: All settings are byte registers picked by a seven-bit address on the control port.
// RULE2: Every register default is copied from the 64-bit factory store after reset; the second enable, address and second-input registers keep reset values.
// RULE3: Gain bits 4:0 pick amplifier count and series resistance, other codes are reserved.
// RULE4: Load bits 0 to 6 each switch one binary-weighted capacitor and bit 7 is reserved.
// RULE5: With the run-policy bit set the oscillator runs only while crystal mode is selected.
// RULE6: With the run-policy bit clear the oscillator keeps running for any selected source.
// RULE7: Software should leave the run-policy bit at one for the best jitter.
// RULE8: The source field picks input zero, input one, crystal, or bypass with buffer off.
// RULE9: Bits 7:6 of the first disabled-state register give output three its disabled drive.
// RULE10: Bits 5:4 of the first disabled-state register give output two its disabled drive.
// RULE11: The high disabled-state and second enable registers exist only with twelve outputs.
// RULE12: Disabled drive codes are 00 both low, 01 true low and complement high, 1x high-z.
// RULE13: Software should set a disabled-state field before changing that output's enable.
// RULE14: Unused bits and unassigned addresses read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none

module cbcr_regs #(
    parameter int         NUM_OUTPUTS = 12,     // 8 or 12 outputs
    parameter logic [7:0] DEVICE_ID   = 8'h5a   // Arbitrary identity value
) (
    input  wire logic                                 clock,       // 40 MHz clock
    input  wire logic                                 rstn,        // Async reset, low
    input  wire logic [cbcr_pkg::OTP_W-1:0]           otp_bits,    // Factory defaults
    input  wire cbcr_pkg::cbcr_req_t                  reg_req,     // Register request
    output cbcr_pkg::cbcr_rsp_t                       reg_rsp,     // Read answer
    output cbcr_pkg::cbcr_xtal_t                      xtal_ctrl,   // Crystal controls
    output logic [cbcr_pkg::SEL_W-1:0]                ref_select,  // Reference route
    output cbcr_pkg::cbcr_drive_t [NUM_OUTPUTS-1:0]   out_drive,   // Per-output drive
    output logic [cbcr_pkg::DEVA_W-1:0]               bus_addr_cfg,// Address setting
    output logic [7:0]                                in1_ctrl,    // Second input control
    output logic                                      cfg_loaded   // Defaults copied
);

    localparam bit WIDE = (NUM_OUTPUTS > 8);

    // ------------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------------
    function automatic logic [3:0] amp_of(input logic [cbcr_pkg::GAIN_W-1:0] g);
        unique case (g)
            cbcr_pkg::GAIN_A1:  amp_of = 4'h1;
            cbcr_pkg::GAIN_A2:  amp_of = 4'h2;
            cbcr_pkg::GAIN_A3:  amp_of = 4'h3;
            cbcr_pkg::GAIN_A4R: amp_of = 4'h4;
            cbcr_pkg::GAIN_A4:  amp_of = 4'h4;
            cbcr_pkg::GAIN_A8:  amp_of = 4'h8;
            cbcr_pkg::GAIN_A12: amp_of = 4'hc;
            default:            amp_of = 4'h0;
        endcase
    endfunction

    function automatic cbcr_pkg::cbcr_res_t res_of(input logic [cbcr_pkg::GAIN_W-1:0] g);
        unique case (g)
            cbcr_pkg::GAIN_A1, cbcr_pkg::GAIN_A2, cbcr_pkg::GAIN_A3: res_of = cbcr_pkg::RES_550;
            cbcr_pkg::GAIN_A4R: res_of = cbcr_pkg::RES_150;
            cbcr_pkg::GAIN_A4, cbcr_pkg::GAIN_A8, cbcr_pkg::GAIN_A12: res_of = cbcr_pkg::RES_0;
            default: res_of = cbcr_pkg::RES_OPEN;
        endcase
    endfunction

    function automatic cbcr_pkg::cbcr_drive_t drive_of(input logic en, input logic [1:0] code);
        if (en) begin
            drive_of = cbcr_pkg::DRV_ACTIVE;
        end else if (code == cbcr_pkg::DST_BOTH_LOW) begin
            drive_of = cbcr_pkg::DRV_BOTH_LOW;
        end else if (code == cbcr_pkg::DST_DRIVE_LOW) begin
            drive_of = cbcr_pkg::DRV_TRUE_LOW;
        end else begin
            drive_of = cbcr_pkg::DRV_HIGH_Z;
        end
    endfunction

    // ------------------------------------------------------------------
    // State and storage
    // ------------------------------------------------------------------
    cbcr_pkg::cbcr_state_t               state_q;
    logic [cbcr_pkg::GAIN_W-1:0]         gain_q;
    logic [cbcr_pkg::CAP_W-1:0]          cap_q;
    logic                                run_q;
    logic [cbcr_pkg::SEL_W-1:0]          sel_q;
    logic [23:0]                         dst_q;
    logic [15:0]                         oen_q;
    logic [cbcr_pkg::DEVA_W-1:0]         deva_q;
    logic [7:0]                          in1c_q;
    logic [7:0]                          rd_byte;
    logic                                wr_ok;

    assign wr_ok = (state_q == cbcr_pkg::ST_RUN) && reg_req.wr;

    // ------------------------------------------------------------------
    // Default load sequencing
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= cbcr_pkg::ST_LOAD;
        end else begin
            state_q <= cbcr_pkg::ST_RUN;
        end
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // RULE2 factory default copy
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            gain_q <= cbcr_pkg::RST_GAIN;
            cap_q  <= cbcr_pkg::RST_CAP;
            run_q  <= cbcr_pkg::RST_RUN;
            sel_q  <= cbcr_pkg::RST_SEL;
        end else if (state_q == cbcr_pkg::ST_LOAD) begin
            gain_q <= otp_bits[cbcr_pkg::OTP_GAIN_LSB +: cbcr_pkg::GAIN_W];
            cap_q  <= otp_bits[cbcr_pkg::OTP_CAP_LSB +: cbcr_pkg::CAP_W];
            run_q  <= otp_bits[cbcr_pkg::OTP_RUN_LSB];
            sel_q  <= otp_bits[cbcr_pkg::OTP_SEL_LSB +: cbcr_pkg::SEL_W];
        end else if (wr_ok) begin
            // RULE1 byte address decode
            unique case (reg_req.addr)
                cbcr_pkg::ADDR_GAIN: gain_q <= reg_req.wdata[cbcr_pkg::GAIN_W-1:0];
                cbcr_pkg::ADDR_CAP:  cap_q  <= reg_req.wdata[cbcr_pkg::CAP_W-1:0];
                cbcr_pkg::ADDR_RUN:  run_q  <= reg_req.wdata[0];
                cbcr_pkg::ADDR_SEL:  sel_q  <= reg_req.wdata[cbcr_pkg::SEL_W-1:0];
                default: ;
            endcase
        end
    end

    // RULE11 disabled-state and enable registers, high ones variant-only
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dst_q <= {3{cbcr_pkg::RST_DST}};
            oen_q <= {2{cbcr_pkg::RST_OEN}};
        end else if (state_q == cbcr_pkg::ST_LOAD) begin
            dst_q[7:0]   <= otp_bits[cbcr_pkg::OTP_DST0_LSB +: 8];
            dst_q[15:8]  <= otp_bits[cbcr_pkg::OTP_DST1_LSB +: 8];
            dst_q[23:16] <= WIDE ? otp_bits[cbcr_pkg::OTP_DST2_LSB +: 8] : 8'h00;
            oen_q[7:0]   <= otp_bits[cbcr_pkg::OTP_OEN0_LSB +: 8];
            oen_q[15:8]  <= cbcr_pkg::RST_OEN;
        end else if (wr_ok) begin
            unique case (reg_req.addr)
                cbcr_pkg::ADDR_DST0: dst_q[7:0]  <= reg_req.wdata;
                cbcr_pkg::ADDR_DST1: dst_q[15:8] <= reg_req.wdata;
                cbcr_pkg::ADDR_DST2: begin
                    if (WIDE) begin
                        dst_q[23:16] <= reg_req.wdata;
                    end
                end
                cbcr_pkg::ADDR_OEN0: oen_q[7:0] <= reg_req.wdata;
                cbcr_pkg::ADDR_OEN1: begin
                    if (WIDE) begin
                        oen_q[15:8] <= {4'h0, reg_req.wdata[3:0]};
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            deva_q <= cbcr_pkg::RST_DEVA;
            in1c_q <= cbcr_pkg::RST_IN1C;
        end else if (wr_ok && reg_req.addr == cbcr_pkg::ADDR_DEVA) begin
            deva_q <= reg_req.wdata[cbcr_pkg::DEVA_W-1:0];
        end else if (wr_ok && reg_req.addr == cbcr_pkg::ADDR_IN1C) begin
            in1c_q <= reg_req.wdata;
        end
    end

    // ------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------
    // RULE14 zero for unused bits and addresses
    always_comb begin
        rd_byte = 8'h00;
        unique case (reg_req.addr)
            cbcr_pkg::ADDR_GAIN: rd_byte = {3'h0, gain_q};
            cbcr_pkg::ADDR_CAP:  rd_byte = {1'b0, cap_q};
            cbcr_pkg::ADDR_RUN:  rd_byte = {7'h00, run_q};
            cbcr_pkg::ADDR_SEL:  rd_byte = {6'h00, sel_q};
            cbcr_pkg::ADDR_DST0: rd_byte = dst_q[7:0];
            cbcr_pkg::ADDR_DST1: rd_byte = dst_q[15:8];
            cbcr_pkg::ADDR_DST2: rd_byte = WIDE ? dst_q[23:16] : 8'h00;
            cbcr_pkg::ADDR_OEN0: rd_byte = oen_q[7:0];
            cbcr_pkg::ADDR_OEN1: rd_byte = WIDE ? oen_q[15:8] : 8'h00;
            cbcr_pkg::ADDR_DEVA: rd_byte = {5'h00, deva_q};
            cbcr_pkg::ADDR_ID:   rd_byte = DEVICE_ID;
            cbcr_pkg::ADDR_IN1C: rd_byte = in1c_q;
            default:             rd_byte = 8'h00;
        endcase
    end

    // RULE1 read answer one cycle later
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reg_rsp <= '0;
        end else begin
            reg_rsp.valid <= reg_req.rd;
            reg_rsp.rdata <= reg_req.rd ? rd_byte : 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Crystal and reference controls
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            xtal_ctrl  <= '0;
            ref_select <= cbcr_pkg::RST_SEL;
        end else begin
            // RULE3 gain decode
            xtal_ctrl.amp_count  <= amp_of(gain_q);
            xtal_ctrl.series_res <= res_of(gain_q);
            // RULE4 capacitor bank switches
            xtal_ctrl.load_cap   <= cap_q;
            // RULE5 RULE6 oscillator run policy
            xtal_ctrl.osc_run    <= !run_q || (sel_q == cbcr_pkg::SEL_XTAL);
            // RULE8 bypass disables crystal buffer
            xtal_ctrl.bypass     <= (sel_q == cbcr_pkg::SEL_BYP);
            ref_select           <= sel_q;
        end
    end

    // ------------------------------------------------------------------
    // Output drive and misc outputs
    // ------------------------------------------------------------------
    // RULE9 RULE10 RULE12 disabled drive per output
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_OUTPUTS; i++) begin
                out_drive[i] <= cbcr_pkg::DRV_BOTH_LOW;
            end
        end else begin
            for (int i = 0; i < NUM_OUTPUTS; i++) begin
                out_drive[i] <= drive_of(oen_q[i], dst_q[2*i +: 2]);
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bus_addr_cfg <= cbcr_pkg::RST_DEVA;
            in1_ctrl     <= cbcr_pkg::RST_IN1C;
            cfg_loaded   <= 1'b0;
        end else begin
            bus_addr_cfg <= deva_q;
            in1_ctrl     <= in1c_q;
            cfg_loaded   <= (state_q == cbcr_pkg::ST_RUN);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_read_answer;
        @(posedge clock) disable iff (!rstn) reg_req.rd |=> reg_rsp.valid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered"); // RULE1

    property p_otp_load;
        @(posedge clock) disable iff (!rstn)
        (state_q == cbcr_pkg::ST_LOAD) |=> (gain_q == $past(otp_bits[4:0]))
            && (run_q == $past(otp_bits[cbcr_pkg::OTP_RUN_LSB]));
    endproperty
    a_otp_load: assert property (p_otp_load) else $error("defaults not from store"); // RULE2

    property p_gain12;
        @(posedge clock) disable iff (!rstn)
        (wr_ok && reg_req.addr == cbcr_pkg::ADDR_GAIN && reg_req.wdata[4:0] == 5'h18)
            |-> ##2 (xtal_ctrl.amp_count == 4'hc && xtal_ctrl.series_res == cbcr_pkg::RES_0);
    endproperty
    a_gain12: assert property (p_gain12) else $error("gain code 24 misdecoded"); // RULE3

    property p_cap_write;
        @(posedge clock) disable iff (!rstn)
        (wr_ok && reg_req.addr == cbcr_pkg::ADDR_CAP)
            |-> ##2 (xtal_ctrl.load_cap == $past(reg_req.wdata[6:0], 2));
    endproperty
    a_cap_write: assert property (p_cap_write) else $error("load cap not applied"); // RULE4

    property p_osc_stop;
        @(posedge clock) disable iff (!rstn)
        (run_q && sel_q != cbcr_pkg::SEL_XTAL) |=> !xtal_ctrl.osc_run;
    endproperty
    a_osc_stop: assert property (p_osc_stop) else $error("oscillator not stopped"); // RULE5

    property p_osc_keep;
        @(posedge clock) disable iff (!rstn) !run_q |=> xtal_ctrl.osc_run;
    endproperty
    a_osc_keep: assert property (p_osc_keep) else $error("oscillator stopped"); // RULE6

    property p_bypass;
        @(posedge clock) disable iff (!rstn)
        (sel_q == cbcr_pkg::SEL_BYP) |=> (xtal_ctrl.bypass && ref_select == 2'h3);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass route wrong"); // RULE8

    property p_clock_output_three_off;
        @(posedge clock) disable iff (!rstn)
        (!oen_q[3] && dst_q[7:6] == 2'h0) |=> (out_drive[3] == cbcr_pkg::DRV_BOTH_LOW);
    endproperty
    a_clock_output_three_off: assert property (p_clock_output_three_off) else $error("output three drive wrong"); // RULE9

    property p_out2_off;
        @(posedge clock) disable iff (!rstn)
        (!oen_q[2] && dst_q[5:4] == 2'h1) |=> (out_drive[2] == cbcr_pkg::DRV_TRUE_LOW);
    endproperty
    a_out2_off: assert property (p_out2_off) else $error("output two drive wrong"); // RULE10

    property p_hiz;
        @(posedge clock) disable iff (!rstn)
        (!oen_q[0] && dst_q[1]) |=> (out_drive[0] == cbcr_pkg::DRV_HIGH_Z);
    endproperty
    a_hiz: assert property (p_hiz) else $error("high-z code not applied"); // RULE12

    property p_narrow;
        @(posedge clock) disable iff (!rstn)
        (!WIDE && reg_req.rd && reg_req.addr == cbcr_pkg::ADDR_DST2) |=> (reg_rsp.rdata == 8'h00);
    endproperty
    a_narrow: assert property (p_narrow) else $error("absent register read nonzero"); // RULE11

    property p_unmapped;
        @(posedge clock) disable iff (!rstn)
        (reg_req.rd && reg_req.addr == 7'h0c) |=> (reg_rsp.valid && reg_rsp.rdata == 8'h00);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero"); // RULE14

    c_xtal_run: cover property (@(posedge clock) disable iff (!rstn)
        run_q && sel_q == cbcr_pkg::SEL_XTAL ##1 xtal_ctrl.osc_run);
    c_out_disable: cover property (@(posedge clock) disable iff (!rstn)
        $fell(oen_q[0]) ##1 out_drive[0] != cbcr_pkg::DRV_ACTIVE);
    c_id_read: cover property (@(posedge clock) disable iff (!rstn)
        reg_req.rd && reg_req.addr == cbcr_pkg::ADDR_ID ##1 reg_rsp.valid);
    c_gain_write: cover property (@(posedge clock) disable iff (!rstn)
        wr_ok && reg_req.addr == cbcr_pkg::ADDR_GAIN);

endmodule

`default_nettype wire

/* File: inc/cbcr_pkg.sv */
// Constants and types shared by the clock buffer configuration register bank
`default_nettype none

package cbcr_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int OTP_W  = 64;
    localparam int GAIN_W = 5;
    localparam int CAP_W  = 7;
    localparam int SEL_W  = 2;
    localparam int DEVA_W = 3;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_GAIN = 7'h00;
    localparam logic [ADDR_W-1:0] ADDR_RSVD = 7'h01;
    localparam logic [ADDR_W-1:0] ADDR_CAP  = 7'h02;
    localparam logic [ADDR_W-1:0] ADDR_RUN  = 7'h03;
    localparam logic [ADDR_W-1:0] ADDR_SEL  = 7'h04;
    localparam logic [ADDR_W-1:0] ADDR_DST0 = 7'h05;
    localparam logic [ADDR_W-1:0] ADDR_DST1 = 7'h06;
    localparam logic [ADDR_W-1:0] ADDR_DST2 = 7'h07;
    localparam logic [ADDR_W-1:0] ADDR_OEN0 = 7'h08;
    localparam logic [ADDR_W-1:0] ADDR_OEN1 = 7'h09;
    localparam logic [ADDR_W-1:0] ADDR_DEVA = 7'h0a;
    localparam logic [ADDR_W-1:0] ADDR_ID   = 7'h0b;
    localparam logic [ADDR_W-1:0] ADDR_IN1C = 7'h0d;

    // ------------------------------------------------------------------
    // Reset values before the factory store is copied in
    // ------------------------------------------------------------------
    localparam logic [GAIN_W-1:0] RST_GAIN = 5'h04;
    localparam logic [CAP_W-1:0]  RST_CAP  = 7'h40;
    localparam logic              RST_RUN  = 1'b1;
    localparam logic [SEL_W-1:0]  RST_SEL  = 2'h0;
    localparam logic [7:0]        RST_DST  = 8'h00;
    localparam logic [7:0]        RST_OEN  = 8'h00;
    localparam logic [DEVA_W-1:0] RST_DEVA = 3'h0;
    localparam logic [7:0]        RST_IN1C = 8'h00;

    // ------------------------------------------------------------------
    // Field codes
    // ------------------------------------------------------------------
    localparam logic [GAIN_W-1:0] GAIN_OPEN = 5'h00;
    localparam logic [GAIN_W-1:0] GAIN_A1   = 5'h01;
    localparam logic [GAIN_W-1:0] GAIN_A2   = 5'h02;
    localparam logic [GAIN_W-1:0] GAIN_A3   = 5'h03;
    localparam logic [GAIN_W-1:0] GAIN_A4R  = 5'h04;
    localparam logic [GAIN_W-1:0] GAIN_A4   = 5'h08;
    localparam logic [GAIN_W-1:0] GAIN_A8   = 5'h10;
    localparam logic [GAIN_W-1:0] GAIN_A12  = 5'h18;

    localparam logic [SEL_W-1:0] SEL_IN0  = 2'h0;
    localparam logic [SEL_W-1:0] SEL_IN1  = 2'h1;
    localparam logic [SEL_W-1:0] SEL_XTAL = 2'h2;
    localparam logic [SEL_W-1:0] SEL_BYP  = 2'h3;

    localparam logic [1:0] DST_BOTH_LOW  = 2'h0;
    localparam logic [1:0] DST_DRIVE_LOW = 2'h1;

    // ------------------------------------------------------------------
    // Factory store bit positions
    // ------------------------------------------------------------------
    localparam int OTP_GAIN_LSB = 0;
    localparam int OTP_CAP_LSB  = 8;
    localparam int OTP_RUN_LSB  = 16;
    localparam int OTP_SEL_LSB  = 24;
    localparam int OTP_DST0_LSB = 32;
    localparam int OTP_DST1_LSB = 40;
    localparam int OTP_DST2_LSB = 48;
    localparam int OTP_OEN0_LSB = 56;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } cbcr_req_t;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] rdata;
    } cbcr_rsp_t;

    typedef enum logic [1:0] {RES_OPEN, RES_550, RES_150, RES_0} cbcr_res_t;

    typedef enum logic [1:0] {DRV_ACTIVE, DRV_BOTH_LOW, DRV_TRUE_LOW, DRV_HIGH_Z} cbcr_drive_t;

    typedef enum logic {ST_LOAD, ST_RUN} cbcr_state_t;

    typedef struct packed {
        logic [3:0]       amp_count;
        cbcr_res_t        series_res;
        logic [CAP_W-1:0] load_cap;
        logic             osc_run;
        logic             bypass;
    } cbcr_xtal_t;

endpackage

`default_nettype wire

/* File: verification/cbcr_host.sv */
// Behavioural host that issues byte register requests to the bank
`timescale 1ns/1ps
`default_nettype none

module cbcr_host (
    input  wire logic                clock,   // Register clock
    output cbcr_pkg::cbcr_req_t      reg_req, // Request to the bank
    input  wire cbcr_pkg::cbcr_rsp_t reg_rsp  // Read answer
);
    initial reg_req = '0;

    task automatic put(input logic w, input logic [6:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clock);
        reg_req <= '0;
        #1;
    endtask

    task automatic wr_byte(input logic [6:0] a, input logic [7:0] d);
        put(1'b1, a, d);
    endtask

    task automatic rd_byte(input logic [6:0] a, output logic [7:0] d, output logic v);
        put(1'b0, a, 8'h00);
        d = reg_rsp.rdata;
        v = reg_rsp.valid;
    endtask
endmodule

`default_nettype wire

/* File: verification/cbcr_regs_bench.sv */
// Self-checking bench for the clock buffer configuration register bank
`timescale 1ns/1ps
`default_nettype none

module cbcr_regs_bench;
    logic                         clock;
    logic                         rstn;
    logic [63:0]                  otp_bits;
    cbcr_pkg::cbcr_req_t          reg_req;
    cbcr_pkg::cbcr_rsp_t          reg_rsp;
    cbcr_pkg::cbcr_rsp_t          n_rsp;
    cbcr_pkg::cbcr_xtal_t         xtal_ctrl;
    logic [1:0]                   ref_select;
    cbcr_pkg::cbcr_drive_t [11:0] out_drive;
    logic [2:0]                   bus_addr_cfg;
    logic [7:0]                   in1_ctrl;
    logic                         cfg_loaded;
    int                           num_errors;
    int                           n_tests;
    logic [7:0]                   rd_v;
    logic                         ok;
    cbcr_pkg::cbcr_drive_t        ed;
    // Rows: address, write data, expected read back
    logic [22:0] rows [16] = '{{7'h00, 8'hff, 8'h1f}, {7'h02, 8'hff, 8'h7f}, {7'h02, 8'h80, 8'h00},
        {7'h03, 8'hff, 8'h01}, {7'h04, 8'hff, 8'h03}, {7'h05, 8'he4, 8'he4}, {7'h06, 8'h3c, 8'h3c},
        {7'h07, 8'h55, 8'h55}, {7'h08, 8'ha5, 8'ha5}, {7'h09, 8'hff, 8'h0f}, {7'h0a, 8'hff, 8'h07},
        {7'h0b, 8'hff, 8'h5a}, {7'h01, 8'hff, 8'h00}, {7'h0c, 8'hff, 8'h00}, {7'h7f, 8'hff, 8'h00},
        {7'h0d, 8'hc3, 8'hc3}};
    // Gain code, amplifier count, resistance code
    logic [10:0] gains [9] = '{{5'h00, 4'd0, 2'd0}, {5'h01, 4'd1, 2'd1}, {5'h02, 4'd2, 2'd1},
        {5'h03, 4'd3, 2'd1}, {5'h04, 4'd4, 2'd2}, {5'h08, 4'd4, 2'd3}, {5'h10, 4'd8, 2'd3},
        {5'h18, 4'd12, 2'd3}, {5'h05, 4'd0, 2'd0}};

    cbcr_regs #(.NUM_OUTPUTS(12), .DEVICE_ID(8'h5a)) dut (
        .clock(clock), .rstn(rstn), .otp_bits(otp_bits), .reg_req(reg_req), .reg_rsp(reg_rsp),
        .xtal_ctrl(xtal_ctrl), .ref_select(ref_select), .out_drive(out_drive),
        .bus_addr_cfg(bus_addr_cfg), .in1_ctrl(in1_ctrl), .cfg_loaded(cfg_loaded));

    // Eight-output variant sees the same requests
    cbcr_regs #(.NUM_OUTPUTS(8), .DEVICE_ID(8'h5a)) dut8 (
        .clock(clock), .rstn(rstn), .otp_bits(otp_bits), .reg_req(reg_req), .reg_rsp(n_rsp),
        .xtal_ctrl(), .ref_select(), .out_drive(), .bus_addr_cfg(), .in1_ctrl(),
        .cfg_loaded());

    cbcr_host host (.clock(clock), .reg_req(reg_req), .reg_rsp(reg_rsp));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
        host.rd_byte(a, rd_v, ok);
        check({7'h00, ok}, 8'h01);
        check(rd_v, e);
        check(n_rsp.rdata, (a == 7'h07 || a == 7'h09) ? 8'h00 : e);
    endtask

    task automatic do_reset;
        rstn <= 1'b0;
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
    endtask

    task automatic conclude;
        if (num_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        conclude();
    end

    initial begin
        num_errors = 0;
        n_tests = 0;
        rstn = 1'b0;
        otp_bits = 64'h0100_001b_0100_2a18;
        do_reset();
        check({7'h00, cfg_loaded}, 8'h01);
        rdchk(7'h00, 8'h18);
        rdchk(7'h02, 8'h2a);
        rdchk(7'h03, 8'h00);
        rdchk(7'h04, 8'h01);
        rdchk(7'h05, 8'h1b);
        rdchk(7'h08, 8'h01);
        check({4'h0, xtal_ctrl.amp_count}, 8'h0c);
        check({5'h0, xtal_ctrl.osc_run, ref_select}, 8'h05);
        check({out_drive[3], out_drive[2], out_drive[1], out_drive[0]}, 8'h6c);
        foreach (rows[i]) begin
            host.wr_byte(rows[i][22:16], rows[i][15:8]);
            rdchk(rows[i][22:16], rows[i][7:0]);
        end
        check({5'h00, bus_addr_cfg}, 8'h07);
        check(in1_ctrl, 8'hc3);
        host.wr_byte(7'h02, 8'h55);
        @(posedge clock);
        #1;
        check({1'b0, xtal_ctrl.load_cap}, 8'h55);
        foreach (gains[i]) begin
            host.wr_byte(7'h00, {3'h0, gains[i][10:6]});
            @(posedge clock);
            #1;
            check({2'h0, xtal_ctrl.amp_count, xtal_ctrl.series_res}, {2'h0, gains[i][5:0]});
        end
        for (int r = 0; r < 2; r++) begin
            for (int s = 0; s < 4; s++) begin
                host.wr_byte(7'h03, 8'(r));
                host.wr_byte(7'h04, 8'(s));
                @(posedge clock);
                #1;
                check({4'h0, xtal_ctrl.osc_run, xtal_ctrl.bypass, ref_select},
                      {4'h0, r == 0 || s == 2, s == 3, 2'(s)});
            end
        end
        host.wr_byte(7'h03, 8'h01);
        host.wr_byte(7'h08, 8'h00);
        host.wr_byte(7'h09, 8'h00);
        for (int c = 0; c < 4; c++) begin
            ed = (c == 0) ? cbcr_pkg::DRV_BOTH_LOW :
                 (c == 1) ? cbcr_pkg::DRV_TRUE_LOW : cbcr_pkg::DRV_HIGH_Z;
            host.wr_byte(7'h05, {2'(c), 2'(c), 2'b00, 2'(c)});
            host.wr_byte(7'h07, {6'h00, 2'(c)});
            @(posedge clock);
            #1;
            check({out_drive[3], out_drive[2], out_drive[8], 2'b00}, {ed, ed, ed, 2'b00});
            check({6'h00, out_drive[0]}, {6'h00, ed});
        end
        host.wr_byte(7'h08, 8'h08);
        host.wr_byte(7'h09, 8'h01);
        @(posedge clock);
        #1;
        check({out_drive[3], out_drive[2], out_drive[8], 2'b00}, 8'h30);
        check({6'h00, out_drive[0]}, 8'h03);
        do_reset();
        rdchk(7'h00, 8'h18);
        rdchk(7'h0d, 8'h00);
        check(in1_ctrl, 8'h00);
        conclude();
    end
endmodule

`default_nettype wire
